// ==== logic/sws_pkg.sv ====
// Shared constants and types for the standby and watchdog supervisor
package sws_pkg;
	// Clock rate and counter width
	localparam int unsigned CLK_NS         = 8;
	localparam int unsigned CNT_W          = 32;

	// Standby window before the frame supply is cut
	localparam int unsigned STBY_LIMIT_MIN = 15;
	localparam int unsigned STBY_LIMIT_MS  = STBY_LIMIT_MIN * 60 * 1000;
	localparam int unsigned MS_NS          = 1_000_000;
	// Longest interval: round down
	localparam int unsigned MS_CYC         = MS_NS / CLK_NS;

	// DRAM refresh request interval, longest time, rounded down
	localparam int unsigned REFRESH_NS     = 15_625;
	localparam int unsigned REFRESH_CYC    = REFRESH_NS / CLK_NS;

	// Watchdog defaults, no documented values
	localparam int unsigned COP_TIMEOUT_NS  = 10_000_000;
	localparam int unsigned COP_TIMEOUT_CYC = COP_TIMEOUT_NS / CLK_NS;
	localparam int unsigned SW_TIMEOUT_NS   = 1_000_000_000;
	localparam int unsigned SW_TIMEOUT_CYC  = SW_TIMEOUT_NS / CLK_NS;
	localparam int unsigned LINK_TIMEOUT_NS  = 500_000_000;
	localparam int unsigned LINK_TIMEOUT_CYC = LINK_TIMEOUT_NS / CLK_NS;
	localparam int unsigned LINK_TX_NS     = 10_000_000;
	localparam int unsigned LINK_TX_CYC    = LINK_TX_NS / CLK_NS;

	// Reset pulse widths in cycles
	localparam logic [4:0]  COP_RST_CYC    = 5'h10;
	localparam logic [4:0]  SYS_RST_CYC    = 5'h10;

	// Reset values of the start status
	localparam logic        WARM_RST       = 1'b0;

	// Pin vector positions
	localparam int unsigned PIN_STBY       = 0;
	localparam int unsigned PIN_RESTART    = 1;
	localparam int unsigned PIN_COP        = 2;
	localparam int unsigned PIN_LINK       = 3;
	localparam int unsigned PIN_N          = 4;

	// Supervisor operating state
	typedef enum logic {
		SWS_RUN,
		SWS_STANDBY
	} sws_state_type;
endpackage

// ==== logic/sws_supervisor.sv ====
`timescale 1ns/10ps
module sws_supervisor #(
	parameter int unsigned MS_CYC_P       = sws_pkg::MS_CYC,
	parameter int unsigned STBY_LIMIT_P   = sws_pkg::STBY_LIMIT_MS,
	parameter int unsigned COP_TIMEOUT_P  = sws_pkg::COP_TIMEOUT_CYC,
	parameter int unsigned SW_TIMEOUT_P   = sws_pkg::SW_TIMEOUT_CYC,
	parameter int unsigned LINK_TIMEOUT_P = sws_pkg::LINK_TIMEOUT_CYC,
	parameter int unsigned LINK_TX_P      = sws_pkg::LINK_TX_CYC
) (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic sys_rst_i,
	// Pins from outside the clock domain
	input  wire logic standby_req_i,
	input  wire logic restart_i,
	input  wire logic io_coprocessor_beat_i,
	input  wire logic frame_power_manager_rx_i,
	// From processor logic on this clock
	input  wire logic sw_kick_i,
	// Standby control
	output logic      nmi_o,
	output logic      outputs_off_o,
	output logic      cpu_halt_o,
	output logic      refresh_req_o,
	// Watchdog actions
	output logic      io_coprocessor_reset_o,
	output logic      system_reset_o,
	output logic      link_fail_o,
	output logic      frame_power_manager_tx_o,
	// Start status
	output logic      warm_start_o,
	output logic      cold_start_o
);

	logic [sws_pkg::PIN_N-1:0] sync1_q;
	logic [sws_pkg::PIN_N-1:0] sync2_q;
	logic [sws_pkg::PIN_N-1:0] prev_q;
	logic [sws_pkg::PIN_N-1:0] rise;
	sws_pkg::sws_state_type    state_q;
	logic [31:0]               ms_pre_q;
	logic [31:0]               stby_ms_q;
	logic [31:0]               ref_cnt_q;
	logic [31:0]               cop_cnt_q;
	logic [31:0]               sw_cnt_q;
	logic [31:0]               link_cnt_q;
	logic [31:0]               tx_cnt_q;
	logic [4:0]                cop_rst_q;
	logic [4:0]                sys_rst_q;
	logic                      refresh_q;
	logic                      link_fail_q;
	logic                      tx_q;
	logic                      warm_q;
	logic                      running;

	// True when a counter has reached the last cycle of its period
	function automatic logic at_limit(input logic [31:0] cnt, input int unsigned lim);
		at_limit = (cnt >= 32'(lim - 1));
	endfunction

	// Two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= {frame_power_manager_rx_i, io_coprocessor_beat_i, restart_i, standby_req_i};
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end
	assign rise    = sync2_q & ~prev_q;
	assign running = (state_q == sws_pkg::SWS_RUN);

	// Run/standby state
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_q <= sws_pkg::SWS_RUN;
		end else begin
			case (state_q)
				sws_pkg::SWS_RUN: begin
					if (rise[sws_pkg::PIN_STBY]) begin
						state_q <= sws_pkg::SWS_STANDBY;
					end
				end
				sws_pkg::SWS_STANDBY: begin
					if (rise[sws_pkg::PIN_RESTART]) begin
						state_q <= sws_pkg::SWS_RUN;
					end
				end
				default: begin
					state_q <= sws_pkg::SWS_RUN;
				end
			endcase
		end
	end

	// Standby controls decoded straight from the state flop
	// blank outputs with the interrupt
	assign nmi_o         = ~running;
	assign outputs_off_o = ~running;
	assign cpu_halt_o    = ~running;

	// Standby time in ms, saturating; cleared only by a new entry or by sys_rst_i
	// retained standby time
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ms_pre_q  <= '0;
			stby_ms_q <= '0;
		end else if (running) begin
			ms_pre_q  <= '0;
			if (rise[sws_pkg::PIN_STBY]) begin
				stby_ms_q <= '0;
			end
		end else if (at_limit(ms_pre_q, MS_CYC_P)) begin
			ms_pre_q <= '0;
			if (stby_ms_q < 32'(STBY_LIMIT_P)) begin
				stby_ms_q <= stby_ms_q + 32'h1;
			end
		end else begin
			ms_pre_q <= ms_pre_q + 32'h1;
		end
	end

	// Warm or cold start status; power-up means the supply was cut, so cold
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			warm_q <= sws_pkg::WARM_RST;
		end else if (!running && rise[sws_pkg::PIN_RESTART]) begin
			warm_q <= (stby_ms_q < 32'(STBY_LIMIT_P));
		end
	end
	assign warm_start_o = warm_q;
	assign cold_start_o = ~warm_q;

	// Refresh ticker never stops, so DRAM survives the halt
	// refresh continues
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ref_cnt_q <= '0;
			refresh_q <= 1'b0;
		end else if (at_limit(ref_cnt_q, sws_pkg::REFRESH_CYC)) begin
			ref_cnt_q <= '0;
			refresh_q <= 1'b1;
		end else begin
			ref_cnt_q <= ref_cnt_q + 32'h1;
			refresh_q <= 1'b0;
		end
	end
	assign refresh_req_o = refresh_q;

	// Coprocessor heartbeat watchdog, idle in standby since the section sleeps too
	// local coprocessor reset
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			cop_cnt_q <= '0;
			cop_rst_q <= '0;
		end else begin
			if (cop_rst_q != 5'h0) begin
				cop_rst_q <= cop_rst_q - 5'h1;
			end
			if (!running || rise[sws_pkg::PIN_COP] || cop_rst_q != 5'h0) begin
				cop_cnt_q <= '0;
			end else if (at_limit(cop_cnt_q, COP_TIMEOUT_P)) begin
				cop_cnt_q <= '0;
				cop_rst_q <= sws_pkg::COP_RST_CYC;
			end else begin
				cop_cnt_q <= cop_cnt_q + 32'h1;
			end
		end
	end
	assign io_coprocessor_reset_o = (cop_rst_q != 5'h0);

	// Software watchdog; a kick in the expiry cycle still counts as a refresh
	// whole monitor reset
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sw_cnt_q  <= '0;
			sys_rst_q <= '0;
		end else begin
			if (sys_rst_q != 5'h0) begin
				sys_rst_q <= sys_rst_q - 5'h1;
			end
			if (!running || sw_kick_i || sys_rst_q != 5'h0) begin
				sw_cnt_q <= '0;
			end else if (at_limit(sw_cnt_q, SW_TIMEOUT_P)) begin
				sw_cnt_q  <= '0;
				sys_rst_q <= sws_pkg::SYS_RST_CYC;
			end else begin
				sw_cnt_q <= sw_cnt_q + 32'h1;
			end
		end
	end
	assign system_reset_o = (sys_rst_q != 5'h0);

	// Link watchdog: receive edges keep it alive; failure clears on fresh traffic
	// mutual link watchdog
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			link_cnt_q  <= '0;
			link_fail_q <= 1'b0;
		end else if (rise[sws_pkg::PIN_LINK]) begin
			link_cnt_q  <= '0;
			link_fail_q <= 1'b0;
		end else if (at_limit(link_cnt_q, LINK_TIMEOUT_P)) begin
			link_fail_q <= 1'b1;
		end else begin
			link_cnt_q <= link_cnt_q + 32'h1;
		end
	end
	assign link_fail_o = link_fail_q;

	// Outgoing link activity, toggled even in standby so the far end sees us alive
	// transmit heartbeat
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_cnt_q <= '0;
			tx_q     <= 1'b0;
		end else if (at_limit(tx_cnt_q, LINK_TX_P)) begin
			tx_cnt_q <= '0;
			tx_q     <= ~tx_q;
		end else begin
			tx_cnt_q <= tx_cnt_q + 32'h1;
		end
	end
	assign frame_power_manager_tx_o = tx_q;

	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_enter;
		running && rise[sws_pkg::PIN_STBY];
	endsequence
	sequence s_restart;
		!running && rise[sws_pkg::PIN_RESTART];
	endsequence

	a_nmi_on_entry: assert property (s_enter |=> nmi_o && cpu_halt_o)
		else $error("standby entry did not raise interrupt");
	a_outputs_blanked: assert property (nmi_o |-> outputs_off_o)
		else $error("outputs live during standby interrupt");
	a_halt_held: assert property (cpu_halt_o && !rise[sws_pkg::PIN_RESTART] |=> cpu_halt_o)
		else $error("halt released without restart");
	a_refresh_single: assert property (refresh_req_o |=> !refresh_req_o && ref_cnt_q == 32'h1)
		else $error("refresh strobe malformed");
	a_refresh_in_halt: assert property (cpu_halt_o && at_limit(ref_cnt_q, sws_pkg::REFRESH_CYC)
		|=> refresh_req_o)
		else $error("refresh missed while halted");
	a_warm_select: assert property (s_restart and (stby_ms_q < 32'(STBY_LIMIT_P))
		|=> warm_start_o && !cold_start_o && !cpu_halt_o)
		else $error("early restart not warm");
	a_cold_select: assert property (s_restart and (stby_ms_q >= 32'(STBY_LIMIT_P))
		|=> cold_start_o && !warm_start_o)
		else $error("late restart not cold");
	a_cop_local: assert property (running && !rise[sws_pkg::PIN_COP] && cop_rst_q == 5'h0
		&& at_limit(cop_cnt_q, COP_TIMEOUT_P) && sys_rst_q == 5'h0
		|=> io_coprocessor_reset_o [*8] ##0 !system_reset_o)
		else $error("heartbeat loss mishandled");
	a_sw_reset: assert property (running && !sw_kick_i && sys_rst_q == 5'h0
		&& at_limit(sw_cnt_q, SW_TIMEOUT_P) |=> system_reset_o [*8])
		else $error("software watchdog did not reset");
	a_link_fail: assert property (!rise[sws_pkg::PIN_LINK] && at_limit(link_cnt_q, LINK_TIMEOUT_P)
		|=> link_fail_o)
		else $error("link loss not flagged");
	a_link_recover: assert property (rise[sws_pkg::PIN_LINK] |=> !link_fail_o)
		else $error("link failure not cleared by traffic");

endmodule // sws_supervisor

// ==== dv/sws_partner_model.sv ====
`timescale 1ns/10ps
module sws_partner_model (
	// Clock and scenario controls
	input  wire logic clock_i,
	input  wire logic beat_en_i,
	input  wire logic kick_en_i,
	input  wire logic rx_en_i,
	// Towards the supervisor
	output logic      beat_o,
	output logic      kick_o,
	output logic      rx_o
);
	// Outputs settle after the first edge, well inside the bench reset
	int unsigned cnt_q = 0;

	// Free running phase counter
	always @(posedge clock_i) begin
		cnt_q <= cnt_q + 1;
	end

	// coprocessor heartbeat
	// Period 40 stays inside the 50 cycle limit
	always @(posedge clock_i) begin
		beat_o <= #1 beat_en_i && (cnt_q % 40 < 20);
	end

	// Software refresh, one cycle every 30
	always @(posedge clock_i) begin
		kick_o <= #1 kick_en_i && (cnt_q % 30 == 0);
	end

	always @(posedge clock_i) begin
		rx_o <= #1 rx_en_i && ((cnt_q + 7) % 40 < 20);
	end
endmodule // sws_partner_model

// ==== dv/sws_supervisor_bench.sv ====
`timescale 1ns/10ps
module sws_supervisor_bench;
	logic clk, rst, stby, rstrt, beat, kick, rx;
	logic beat_en, kick_en, rx_en;
	logic nmi, off, halt, refr, cop_rst, sys_rst, lfail, tx, warm, cold;
	logic tx_prev;
	int   error_cnt, cmp_count, n;
	logic [7:0] cnt;

	// Shortened timing so every watchdog fires within a short run
	localparam int unsigned MS_T   = 10;
	localparam int unsigned STBY_T = 20;
	localparam int unsigned COP_T  = 50;
	localparam int unsigned SW_T   = 60;
	localparam int unsigned LINK_T = 80;
	localparam int unsigned TX_T   = 10;

	sws_supervisor #(.MS_CYC_P(MS_T), .STBY_LIMIT_P(STBY_T), .COP_TIMEOUT_P(COP_T),
		.SW_TIMEOUT_P(SW_T), .LINK_TIMEOUT_P(LINK_T), .LINK_TX_P(TX_T)) i_sws_supervisor (
		.clock_i(clk), .sys_rst_i(rst), .standby_req_i(stby), .restart_i(rstrt),
		.io_coprocessor_beat_i(beat), .frame_power_manager_rx_i(rx), .sw_kick_i(kick),
		.nmi_o(nmi), .outputs_off_o(off), .cpu_halt_o(halt), .refresh_req_o(refr),
		.io_coprocessor_reset_o(cop_rst), .system_reset_o(sys_rst),
		.link_fail_o(lfail), .frame_power_manager_tx_o(tx),
		.warm_start_o(warm), .cold_start_o(cold));

	sws_partner_model i_sws_partner_model (.clock_i(clk), .beat_en_i(beat_en),
		.kick_en_i(kick_en), .rx_en_i(rx_en), .beat_o(beat), .kick_o(kick), .rx_o(rx));

	// Clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// Power-up state straight after reset release
	task automatic reset_test;
		check("cold at reset", 8'h01, {7'h0, cold});
		check("warm at reset", 8'h00, {7'h0, warm});
		check("nmi at reset", 8'h00, {7'h0, nmi});
		check("halt at reset", 8'h00, {7'h0, halt});
		check("tx at reset", 8'h00, {7'h0, tx});
		$display("reset test done");
	endtask

	// Enter standby, stay k cycles, restart; entry to restart edge is k plus 5
	task automatic standby_for(input int k, input logic exp_warm);
		stby = 1'b1;
		tick(5);
		check("nmi", 8'h01, {7'h0, nmi});
		check("off", 8'h01, {7'h0, off});
		check("halt", 8'h01, {7'h0, halt});
		stby = 1'b0;
		cnt = 8'h00;
		for (n = 0; n < k; n++) begin
			tick(1);
			cnt = cnt + {7'h0, refr};
		end
		// Stay is exactly two refresh periods in the long case
		if (k == 2 * sws_pkg::REFRESH_CYC)
			check("refresh", 8'h02, cnt);
		check("halt held", 8'h01, {7'h0, halt});
		check("off held", 8'h01, {7'h0, off});
		rstrt = 1'b1;
		tick(3);
		rstrt = 1'b0;
		tick(3);
		check("halt end", 8'h00, {7'h0, halt});
		check("nmi end", 8'h00, {7'h0, nmi});
		check("warm", {7'h0, exp_warm}, {7'h0, warm});
		check("cold", {7'h0, ~exp_warm}, {7'h0, cold});
		$display("standby test of %0d cycles done", k);
	endtask

	// Outgoing link activity toggles at a fixed period
	task automatic link_tx_test;
		cnt = 8'h00;
		tx_prev = tx;
		for (n = 0; n < 10 * TX_T; n++) begin
			tick(1);
			cnt = cnt + {7'h0, tx ^ tx_prev};
			tx_prev = tx;
		end
		check("tx toggles", 8'h0a, cnt);
		$display("link transmit test done");
	endtask

	// Stop each partner source in turn and wait for the matching action
	task automatic watchdog_test;
		beat_en = 1'b0;
		for (n = 0; n < COP_T + 20 && cop_rst !== 1'b1; n++) tick(1);
		check("cop reset", 8'h01, {7'h0, cop_rst});
		check("sys quiet", 8'h00, {7'h0, sys_rst});
		beat_en = 1'b1;
		tick(30);
		kick_en = 1'b0;
		for (n = 0; n < SW_T + 20 && sys_rst !== 1'b1; n++) tick(1);
		check("sys reset", 8'h01, {7'h0, sys_rst});
		kick_en = 1'b1;
		rx_en = 1'b0;
		for (n = 0; n < LINK_T + 20 && lfail !== 1'b1; n++) tick(1);
		check("link fail", 8'h01, {7'h0, lfail});
		rx_en = 1'b1;
		tick(45);
		check("link back", 8'h00, {7'h0, lfail});
		$display("watchdog test done");
	endtask

	// Standby left running until the far end cuts the supply
	task automatic power_cut_test;
		stby = 1'b1;
		tick(5);
		stby = 1'b0;
		check("nmi before cut", 8'h01, {7'h0, nmi});
		tick(MS_T * STBY_T);
		// supply removed once the window has run out
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		check("halt after cut", 8'h00, {7'h0, halt});
		check("cold after cut", 8'h01, {7'h0, cold});
		tick(1);
		check("nmi after cut", 8'h00, {7'h0, nmi});
		$display("power cut test done");
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard, tests need about 5000 cycles
	initial begin
		#200_000;
		error_cnt++;
		end_of_test();
	end

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		rst = 1'b1;
		{stby, rstrt} = 2'b00;
		{beat_en, kick_en, rx_en} = 3'b111;
		tick(3);
		rst = 1'b0;
		reset_test();
		tick(20);
		// Long standby must give a cold start
		standby_for(2 * sws_pkg::REFRESH_CYC, 1'b0);
		tick(10);
		// Well inside the 200 cycle window
		standby_for(60, 1'b1);
		tick(10);
		// Last warm stay and first cold stay at the window edge
		standby_for(195, 1'b1);
		tick(10);
		standby_for(196, 1'b0);
		tick(10);
		link_tx_test();
		watchdog_test();
		power_cut_test();
		end_of_test();
	end
endmodule // sws_supervisor_bench
